// ===== rtl/event_io_unit.sv
// Square-wave outputs and timestamped event capture against the adder-based hardware time
`timescale 1ns/1ps
`default_nettype none

//////////////////////////////////////////////////////////////////////////////////////////
module event_io_unit #(
    parameter int FIFO_DEPTH = event_io_pkg::FIFO_DEPTH_DEF,
    parameter int SYNC_STAGES = event_io_pkg::SYNC_STAGES_DEF
)(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Event inputs
    input wire logic capture_in_zero,
    input wire logic capture_in_one,
    // Square outputs with driver enables
    output logic square_out_zero,
    output logic square_out_zero_oe,
    output logic square_out_one,
    output logic square_out_one_oe
);

    localparam int PTR_W = $clog2(FIFO_DEPTH);
    localparam int TW = event_io_pkg::TIME_W;

    generate
        if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
        begin : g_bad_depth
            $error("FIFO_DEPTH must be a power of two of at least 2");
        end
        if (SYNC_STAGES < 2)
        begin : g_bad_sync
            $error("SYNC_STAGES must be at least 2");
        end
    endgenerate

    // Wrap-safe "now has reached target"
    function automatic logic time_reached(input logic [TW-1:0] now, input logic [TW-1:0] target);
        logic [TW-1:0] diff;
        diff = now - target;
        return ~diff[TW-1];
    endfunction

    //////////////////////////////////////////////////////////////////////////////////////
    // Hardware time

    logic [TW-1:0] hw_time;
    logic [TW-1:0] next_hw_time;
    logic [31:0] step;

    always_comb
    begin
        next_hw_time = hw_time + {32'h0, step};
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            hw_time <= '0;
        end
        else
        begin
            hw_time <= next_hw_time;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Event synchronizers and edge detect

    logic [SYNC_STAGES:0] sync0;
    logic [SYNC_STAGES:0] sync1;
    logic [SYNC_STAGES:0] next_sync0;
    logic [SYNC_STAGES:0] next_sync1;
    logic rise0;
    logic rise1;
    logic [31:0] control;

    // Rising-edge sampling only, so no half-period correction is ever due
    always_comb
    begin
        next_sync0 = {sync0[SYNC_STAGES-1:0], capture_in_zero};
        next_sync1 = {sync1[SYNC_STAGES-1:0], capture_in_one};
        rise0 = sync0[SYNC_STAGES-1] & ~sync0[SYNC_STAGES] & control[event_io_pkg::CTL_CAP0_EN];
        rise1 = sync1[SYNC_STAGES-1] & ~sync1[SYNC_STAGES] & control[event_io_pkg::CTL_CAP1_EN];
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            sync0 <= '0;
            sync1 <= '0;
        end
        else
        begin
            sync0 <= next_sync0;
            sync1 <= next_sync1;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Capture zero FIFO and capture one register

    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0] fifo_count;
    logic [PTR_W-1:0] next_wr_ptr;
    logic [PTR_W-1:0] next_rd_ptr;
    logic [PTR_W:0] next_fifo_count;
    logic [TW-1:0] fifo_head;
    logic push;
    logic pop0;
    logic pop1;
    logic fifo_empty;
    logic [TW-1:0] cap1_time;
    logic [TW-1:0] next_cap1_time;
    logic cap1_full;
    logic next_cap1_full;

    always_comb
    begin
        fifo_empty = (fifo_count == '0);
        push = rise0 && (fifo_count != (PTR_W+1)'(FIFO_DEPTH));
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop0 ? rd_ptr + 1'b1 : rd_ptr;
        next_fifo_count = fifo_count + (PTR_W+1)'(push) - (PTR_W+1)'(pop0);
        // A read that frees the register makes room for a new capture in the same cycle
        next_cap1_full = cap1_full & ~pop1;
        next_cap1_time = cap1_time;
        if (rise1 && !next_cap1_full)
        begin
            next_cap1_full = 1'b1;
            next_cap1_time = hw_time;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fifo_count <= '0;
            cap1_time <= '0;
            cap1_full <= 1'b0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            fifo_count <= next_fifo_count;
            cap1_time <= next_cap1_time;
            cap1_full <= next_cap1_full;
        end
    end

    capture_store #(
        .WIDTH(TW),
        .DEPTH(FIFO_DEPTH)
    ) u_store (
        .clk_sys(clk_sys),
        .reset(reset),
        .write(push),
        .waddr(wr_ptr),
        .wdata(hw_time),
        .raddr(rd_ptr),
        .rdata(fifo_head)
    );

    //////////////////////////////////////////////////////////////////////////////////////
    // APB registers

    event_io_pkg::apb_state_t state;
    event_io_pkg::apb_state_t next_state;
    logic [31:0] next_control;
    logic [31:0] next_step;
    logic [TW-1:0] half [2];
    logic [TW-1:0] next_half [2];
    logic [31:0] low_shadow [2];
    logic [31:0] next_low_shadow [2];
    logic [31:0] held_high0;
    logic [31:0] held_high1;
    logic [31:0] held_time_high;
    logic [31:0] next_held_high0;
    logic [31:0] next_held_high1;
    logic [31:0] next_held_time_high;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic take;

    always_comb
    begin
        next_state = state;
        next_control = control;
        next_step = step;
        next_half = half;
        next_low_shadow = low_shadow;
        next_held_high0 = held_high0;
        next_held_high1 = held_high1;
        next_held_time_high = held_time_high;
        next_prdata = prdata;
        next_pready = 1'b0;
        next_pslverr = 1'b0;
        pop0 = 1'b0;
        pop1 = 1'b0;
        take = psel && penable && state == event_io_pkg::st_done;
        case (state)
            event_io_pkg::st_wait:
            begin
                // One wait cycle lets the answer come from flip-flops
                if (psel && penable)
                begin
                    next_state = event_io_pkg::st_done;
                    next_pready = 1'b1;
                    next_prdata = '0;
                    case (paddr)
                        event_io_pkg::CONTROL_OFS: next_prdata = control;
                        event_io_pkg::CAP0_LOW_OFS: next_prdata = fifo_empty ? '0 : fifo_head[31:0];
                        event_io_pkg::CAP0_HIGH_OFS: next_prdata = held_high0;
                        event_io_pkg::CAP1_LOW_OFS: next_prdata = cap1_full ? cap1_time[31:0] : '0;
                        event_io_pkg::CAP1_HIGH_OFS: next_prdata = held_high1;
                        event_io_pkg::HP0_LOW_OFS: next_prdata = half[0][31:0];
                        event_io_pkg::HP0_HIGH_OFS: next_prdata = half[0][63:32];
                        event_io_pkg::HP1_LOW_OFS: next_prdata = half[1][31:0];
                        event_io_pkg::HP1_HIGH_OFS: next_prdata = half[1][63:32];
                        event_io_pkg::STEP_OFS: next_prdata = step;
                        event_io_pkg::STATUS_OFS: next_prdata = 32'(fifo_count)
                            | (32'(cap1_full) << event_io_pkg::STATUS_CAP1_FULL);
                        event_io_pkg::TIME_LOW_OFS: next_prdata = hw_time[31:0];
                        event_io_pkg::TIME_HIGH_OFS: next_prdata = held_time_high;
                        default: next_pslverr = 1'b1;
                    endcase
                end
            end
            event_io_pkg::st_done:
            begin
                next_state = event_io_pkg::st_wait;
                next_prdata = '0;
                if (take && pwrite)
                begin
                    case (paddr)
                        event_io_pkg::CONTROL_OFS: next_control = pwdata & event_io_pkg::CONTROL_MASK;
                        event_io_pkg::HP0_LOW_OFS: next_low_shadow[0] = pwdata;
                        event_io_pkg::HP0_HIGH_OFS: next_half[0] = {pwdata, low_shadow[0]};
                        event_io_pkg::HP1_LOW_OFS: next_low_shadow[1] = pwdata;
                        event_io_pkg::HP1_HIGH_OFS: next_half[1] = {pwdata, low_shadow[1]};
                        event_io_pkg::STEP_OFS: next_step = pwdata;
                        default: next_step = step;
                    endcase
                end
                else if (take)
                begin
                    case (paddr)
                        event_io_pkg::CAP0_LOW_OFS:
                        begin
                            pop0 = !fifo_empty;
                            next_held_high0 = fifo_empty ? '0 : fifo_head[63:32];
                        end
                        event_io_pkg::CAP1_LOW_OFS:
                        begin
                            pop1 = cap1_full;
                            next_held_high1 = cap1_full ? cap1_time[63:32] : '0;
                        end
                        event_io_pkg::TIME_LOW_OFS: next_held_time_high = hw_time[63:32];
                        default: next_held_high0 = held_high0;
                    endcase
                end
            end
            default: next_state = event_io_pkg::st_wait;
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            state <= event_io_pkg::st_wait;
            control <= event_io_pkg::CONTROL_RESET;
            step <= event_io_pkg::STEP_RESET;
            half[0] <= event_io_pkg::HALF_RESET;
            half[1] <= event_io_pkg::HALF_RESET;
            low_shadow[0] <= '0;
            low_shadow[1] <= '0;
            held_high0 <= '0;
            held_high1 <= '0;
            held_time_high <= '0;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            state <= next_state;
            control <= next_control;
            step <= next_step;
            half <= next_half;
            low_shadow <= next_low_shadow;
            held_high0 <= next_held_high0;
            held_high1 <= next_held_high1;
            held_time_high <= next_held_time_high;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////
    // Square output generators

    logic [1:0] running;
    logic [1:0] level;
    logic [1:0] oe;
    logic [TW-1:0] edge_at [2];
    logic [1:0] next_running;
    logic [1:0] next_level;
    logic [1:0] next_oe;
    logic [TW-1:0] next_edge_at [2];
    logic [1:0] fn_en;
    logic [1:0] init_lvl;
    logic [1:0] static_lvl;
    logic [TW-1:0] high_time [2];
    logic [TW-1:0] low_time [2];
    logic duty;

    always_comb
    begin
        duty = control[event_io_pkg::CTL_DUTY_MODE];
        fn_en[0] = control[event_io_pkg::CTL_SQ0_EN];
        fn_en[1] = control[event_io_pkg::CTL_SQ1_EN] & ~duty;
        next_oe[0] = control[event_io_pkg::CTL_SQ0_OE];
        next_oe[1] = control[event_io_pkg::CTL_SQ1_OE] & ~duty;
        init_lvl[0] = control[event_io_pkg::CTL_SQ0_INIT];
        init_lvl[1] = control[event_io_pkg::CTL_SQ1_INIT];
        static_lvl[0] = control[event_io_pkg::CTL_SQ0_LEVEL];
        static_lvl[1] = control[event_io_pkg::CTL_SQ1_LEVEL];
        // High and low phases equal give 50%; duty mode borrows the second half-period
        high_time[0] = half[0];
        low_time[0] = duty ? half[1] : half[0];
        high_time[1] = half[1];
        low_time[1] = half[1];
        for (int i = 0; i < 2; i++)
        begin
            next_running[i] = fn_en[i];
            next_level[i] = level[i];
            next_edge_at[i] = edge_at[i];
            if (!fn_en[i])
            begin
                next_level[i] = static_lvl[i];
            end
            else if (!running[i])
            begin
                next_level[i] = init_lvl[i];
                next_edge_at[i] = hw_time + (init_lvl[i] ? high_time[i] : low_time[i]);
            end
            else if (time_reached(hw_time, edge_at[i]))
            begin
                next_level[i] = ~level[i];
                next_edge_at[i] = edge_at[i] + (level[i] ? low_time[i] : high_time[i]);
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            running <= '0;
            level <= '0;
            oe <= '0;
            edge_at[0] <= '0;
            edge_at[1] <= '0;
        end
        else
        begin
            running <= next_running;
            level <= next_level;
            oe <= next_oe;
            edge_at <= next_edge_at;
        end
    end

    assign square_out_zero = level[0];
    assign square_out_one = level[1];
    assign square_out_zero_oe = oe[0];
    assign square_out_one_oe = oe[1];

endmodule // event_io_unit

`default_nettype wire

// ===== rtl/event_io_pkg.sv
// Shared constants for the timed square outputs and event capture block
package event_io_pkg;

    // Register byte offsets
    localparam logic [11:0] CONTROL_OFS = 12'h04c;
    localparam logic [11:0] CAP0_LOW_OFS = 12'h0a4;
    localparam logic [11:0] CAP0_HIGH_OFS = 12'h0a8;
    localparam logic [11:0] CAP1_LOW_OFS = 12'h0b0;
    localparam logic [11:0] CAP1_HIGH_OFS = 12'h0b4;
    localparam logic [11:0] HP0_LOW_OFS = 12'h0f0;
    localparam logic [11:0] HP0_HIGH_OFS = 12'h0f4;
    localparam logic [11:0] HP1_LOW_OFS = 12'h0f8;
    localparam logic [11:0] HP1_HIGH_OFS = 12'h0fc;
    localparam logic [11:0] STEP_OFS = 12'h100;
    localparam logic [11:0] STATUS_OFS = 12'h104;
    localparam logic [11:0] TIME_LOW_OFS = 12'h108;
    localparam logic [11:0] TIME_HIGH_OFS = 12'h10c;

    // Control field positions
    localparam int CTL_CAP0_EN = 0;
    localparam int CTL_CAP1_EN = 1;
    localparam int CTL_SQ0_EN = 4;
    localparam int CTL_SQ1_EN = 5;
    localparam int CTL_SQ0_OE = 6;
    localparam int CTL_SQ1_OE = 7;
    localparam int CTL_SQ0_INIT = 8;
    localparam int CTL_SQ0_LEVEL = 9;
    localparam int CTL_SQ1_INIT = 10;
    localparam int CTL_SQ1_LEVEL = 11;
    localparam int CTL_DUTY_MODE = 12;
    localparam logic [31:0] CONTROL_MASK = 32'h0000_1ff3;
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

    // Status field positions
    localparam int STATUS_CAP1_FULL = 8;

    // Hardware time: nanoseconds with 16 fractional bits
    localparam int TIME_W = 64;
    localparam int FRAC_BITS = 16;
    localparam int CLK_PERIOD_NS = 4;
    localparam logic [31:0] STEP_RESET = 32'(CLK_PERIOD_NS << FRAC_BITS);
    localparam logic [63:0] HALF_RESET = 64'h0;

    // Structure defaults
    localparam int FIFO_DEPTH_DEF = 16;
    localparam int SYNC_STAGES_DEF = 3;

    typedef enum logic {st_wait, st_done} apb_state_t;

endpackage

// ===== rtl/capture_store.sv
// Timestamp storage array with registered read data and write bypass
`timescale 1ns/1ps
`default_nettype none

module capture_store #(
    parameter int WIDTH = 64,
    parameter int DEPTH = 16
)(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Write side
    input wire logic write,
    input wire logic [$clog2(DEPTH)-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // Read side
    input wire logic [$clog2(DEPTH)-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);

    logic [WIDTH-1:0] mem [DEPTH];

    always_ff @(posedge clk_sys)
    begin
        if (write)
        begin
            mem[waddr] <= wdata;
        end
    end

    // Bypass keeps the head word valid the cycle after a push into an empty store
    always_ff @(posedge clk_sys)
    begin
        if (reset)
        begin
            rdata <= '0;
        end
        else if (write && waddr == raddr)
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem[raddr];
        end
    end

endmodule // capture_store

`default_nettype wire

// ===== dv/event_io_unit_asserts.sv
// Port-level checker for the event I/O unit
`timescale 1ns/1ps
`default_nettype none

module event_io_unit_asserts (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // APB
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic capture_in_zero,
    input wire logic capture_in_one,
    input wire logic square_out_zero,
    input wire logic square_out_zero_oe,
    input wire logic square_out_one,
    input wire logic square_out_one_oe
);
default clocking @(posedge clk_sys);
endclocking
default disable iff (reset);

// Completing control write
logic ctl_wr;
assign ctl_wr = psel && penable && pready && pwrite && paddr == 12'h04c;

////////////////////////////////////////
a_ready_wait: assert property (psel && !penable && !pready |=> !pready ##1 pready)
    else $error("answer not in second access cycle");
a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready stood more than one cycle");
a_ready_cause: assert property (pready |-> psel && penable)
    else $error("ready outside an access phase");
a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused transfer returned data");
a_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside the answer cycle");
a_bad_addr: assert property (psel && penable && pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("unaligned address not refused");
a_ctl_ok: assert property (ctl_wr |-> !pslverr)
    else $error("control write refused");
a_start_high: assert property (
    ctl_wr && pwdata == 32'h0000_0150 && !square_out_zero_oe |-> ##[1:2] (square_out_zero_oe && square_out_zero))
    else $error("output zero did not start high and driven");
a_oe0_cause: assert property ($changed(square_out_zero_oe) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("driver zero changed without a control write");
a_oe1_cause: assert property ($changed(square_out_one_oe) |-> $past(ctl_wr) || $past(ctl_wr, 2))
    else $error("driver one changed without a control write");
endmodule // event_io_unit_asserts

bind event_io_unit event_io_unit_asserts i_asserts (.clk_sys(clk_sys), .reset(reset), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in_zero(capture_in_zero), .capture_in_one(capture_in_one),
    .square_out_zero(square_out_zero), .square_out_zero_oe(square_out_zero_oe),
    .square_out_one(square_out_one), .square_out_one_oe(square_out_one_oe));
`default_nettype wire

// ===== dv/event_source.sv
// Far-side source that drives the two event input lines
`timescale 1ns/1ps
`default_nettype none

module event_source (
    // Clock and time view
    input wire logic clk_sys,
    input wire logic [63:0] now_time,
    // Event lines
    output var logic capture_in_zero,
    output var logic capture_in_one
);
initial
begin
    capture_in_zero = 1'b0;
    capture_in_one = 1'b0;
end

// Low time kept so every stage sees the line fall between pulses
task automatic pulse(input int ch, input int hi, input int lo, output logic [63:0] launch);
    @(posedge clk_sys);
    if (ch == 0)
        capture_in_zero <= 1'b1;
    else
        capture_in_one <= 1'b1;
    @(negedge clk_sys);
    launch = now_time;
    repeat (hi) @(posedge clk_sys);
    capture_in_zero <= 1'b0;
    capture_in_one <= 1'b0;
    repeat (lo) @(posedge clk_sys);
endtask
endmodule // event_source
`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the event I/O unit
`timescale 1ns/1ps
`default_nettype none

module testbench;
localparam logic [63:0] STEP = 64'(event_io_pkg::STEP_RESET);
logic clk_sys = 1'b0;
logic reset = 1'b1;
logic [11:0] paddr = 12'h000;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [31:0] pwdata = 32'h0;
logic [31:0] prdata;
logic pready, pslverr, capture_in_zero, capture_in_one;
logic square_out_zero, square_out_zero_oe, square_out_one, square_out_one_oe;
logic [63:0] hw_now = 64'h0;
logic [63:0] cap_q[$];
int err_count = 0;
int check_count = 0;
int seed = 89305;

always #2 clk_sys = ~clk_sys;
always @(posedge clk_sys) hw_now <= reset ? 64'h0 : hw_now + STEP;

event_io_unit i_event_io_unit (.clk_sys(clk_sys), .reset(reset), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .capture_in_zero(capture_in_zero), .capture_in_one(capture_in_one),
    .square_out_zero(square_out_zero), .square_out_zero_oe(square_out_zero_oe),
    .square_out_one(square_out_one), .square_out_one_oe(square_out_one_oe));
event_source i_event_source (.clk_sys(clk_sys), .now_time(hw_now),
    .capture_in_zero(capture_in_zero), .capture_in_one(capture_in_one));

////////////////////////////////////////
task automatic end_of_test;
    $display("Checks %0d, errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
        $display("*** PASS ***");
    else
        $display("*** FAIL ***");
    $finish;
endtask

task automatic timeout(input string w);
    err_count++;
    $display("ERROR %0t wait for %s ran out", $time, w);
    end_of_test();
endtask

task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    check_count++;
    if (got !== exp)
    begin
        err_count++;
        $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
    end
endtask

// Released address shows the inverted request and data fresh junk, never the last request
task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic e);
    int n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do
    begin
        @(posedge clk_sys);
        n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
        timeout("bus");
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= 32'($random(seed));
endtask

task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
endtask

task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
endtask

// Cycles until the chosen output changes level
task automatic gap(input logic ch, output int c);
    logic prev;
    prev = ch ? square_out_one : square_out_zero;
    c = 0;
    do
    begin
        @(posedge clk_sys);
        c++;
    end while ((ch ? square_out_one : square_out_zero) === prev && c < 200);
    if (c >= 200)
        timeout("square edge");
endtask

task automatic sq_run(input logic ch, input logic [63:0] hi, input logic [63:0] lo);
    int c;
    int sum = 0;
    logic [63:0] ph;
    gap(ch, c);
    check(ch ? square_out_one : square_out_zero, 64'h0, "first toggle level");
    for (int i = 0; i < 4; i++)
    begin
        ph = i[0] ? hi : lo;
        gap(ch, c);
        sum += c;
        check(c * STEP + STEP > ph && c * STEP < ph + STEP, 64'h1, "edge late or early");
    end
    check(sum, 2 * (hi + lo) / STEP, "period drift");
endtask

////////////////////////////////////////
initial
begin
    repeat (50000) @(posedge clk_sys);
    timeout("whole run");
end

initial
begin
    logic [31:0] r;
    logic [31:0] r2;
    logic [63:0] t;
    logic [63:0] x;
    logic e;
    int n;
    repeat (3) @(posedge clk_sys);
    reset <= 1'b0;
    rd(12'h04c, r);
    check(r, 32'h0, "control after reset");
    apb(1'b0, 12'h200, 32'h0, r, e);
    check({e, r}, 33'h1_0000_0000, "unmapped read");
    apb(1'b1, 12'h04e, 32'h150, r, e);
    check(e, 1'b1, "unaligned write");
    rd(12'h04c, r);
    check(r, 32'h0, "refused write changed control");
    rd(12'h0a4, r);
    rd(12'h0a8, r2);
    check({r2, r}, 64'h0, "empty capture pair");
    rd(12'h108, r);
    rd(12'h108, r2);
    check(r2 - r, 32'(4 * STEP), "time advance");
    // Overfill the deep capture store, then drain it
    wr(12'h04c, 32'h1);
    for (int i = 0; i < 18; i++)
    begin
        i_event_source.pulse(0, 4, 3 + ($unsigned($random(seed)) % 8), t);
        if (cap_q.size() < 16)
            cap_q.push_back(t + 3 * STEP);
    end
    repeat (6) @(posedge clk_sys);
    n = 0;
    do
    begin
        rd(12'h0a4, r);
        rd(12'h0a8, r2);
        x = cap_q.size() > 0 ? cap_q.pop_front() : 64'h0;
        check({r2, r}, x, "capture zero stamp");
        n++;
    end while (x != 64'h0 && n < 20);
    check(n, 17, "stored capture count");
    // Single-register input; input zero now disabled
    wr(12'h04c, 32'h2);
    i_event_source.pulse(1, 4, 4, t);
    i_event_source.pulse(0, 4, 4, x);
    rd(12'h0b0, r);
    rd(12'h0b4, r2);
    check({r2, r}, t + 3 * STEP, "capture one stamp");
    rd(12'h0a4, r);
    check(r, 32'h0, "disabled input captured");
    // Half period of 10.5 clocks on output zero
    wr(12'h0f0, 32'h002a_0000);
    wr(12'h0f4, 32'h0);
    wr(12'h04c, 32'h150);
    repeat (3) @(posedge clk_sys);
    check({square_out_zero_oe, square_out_zero}, 2'b11, "start level");
    sq_run(1'b0, 64'h2a_0000, 64'h2a_0000);
    wr(12'h04c, 32'h140);
    repeat (3) @(posedge clk_sys);
    check({square_out_zero_oe, square_out_zero}, 2'b10, "stopped level");
    // Output one on its own half period
    wr(12'h0f8, 32'h0028_0000);
    wr(12'h0fc, 32'h0);
    wr(12'h04c, 32'h4a0);
    repeat (3) @(posedge clk_sys);
    check({square_out_one_oe, square_out_one}, 2'b11, "output one start");
    sq_run(1'b1, 64'h28_0000, 64'h28_0000);
    // Duty mode: high from half zero, low from half one
    wr(12'h0f8, 32'h0050_0000);
    wr(12'h0fc, 32'h0);
    wr(12'h04c, 32'h11f0);
    repeat (3) @(posedge clk_sys);
    check({square_out_zero_oe, square_out_zero, square_out_one_oe}, 3'b110, "duty start");
    sq_run(1'b0, 64'h2a_0000, 64'h50_0000);
    end_of_test();
end
endmodule // testbench
`default_nettype wire
